/* File: src/tmc_timer16.sv */
// 16-bit timer/event counter with two capture/compare registers, one-shot output, AXI4-Lite registers
//
// Notes on behaviour
// - an external trigger arriving while the one-shot pulse is active is ignored.
// - start is not aligned to the count clock; first match may vary one period.
// - external trigger edge still starts a pulse in soft-triggered one-shot mode.
// - counter rolling from all ones to zero sets the overflow flag.
// - overflow flag cleared before counter reaches one is set again.
// - capture beats a simultaneous software access to the capture register.
// - reading the counter never captures into the second register.
// - trigger and capture pins are ignored while the timer is stopped.
// - no capture from the trigger input while its edge is the count clock.
// - capture latches on count clock fall; interrupt on the next rise.
// - a register set to compare does not capture.
// - pin high after reset reads as a rise at first enable only.
// - filter samples on main clock when the external count clock is selected, on the prescaled clock otherwise, for counting and capture alike.
// - any nonzero run-mode value starts counting at once; zero stops.
// - one-shot trigger clears and starts; output set at whichever register matches first, cleared at the other.
// - valid edge is rising, falling or both.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16
	import tmc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus
	input wire tmc_axi_req_t axi_req,
	output tmc_axi_rsp_t axi_rsp,
	// trigger and capture pins
	input wire logic trigger_input_first,
	input wire logic capture_input_second,
	// outputs
	output logic timer_output_pin,
	output logic match_irq_first,
	output logic match_irq_second
);
	function automatic tmc_reg_t reg_decode(input logic [31:0] addr);
		case (addr)
			OFS_MODE: reg_decode = REG_MODE;
			OFS_CCR: reg_decode = REG_CCR;
			OFS_PRM: reg_decode = REG_PRM;
			OFS_OUT: reg_decode = REG_OUT;
			OFS_CNT: reg_decode = REG_CNT;
			OFS_FIRST: reg_decode = REG_FIRST;
			OFS_SECOND: reg_decode = REG_SECOND;
			default: reg_decode = REG_NONE;
		endcase
	endfunction : reg_decode

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		strb_merge = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				strb_merge[b*8 +: 8] = data[b*8 +: 8];
	endfunction : strb_merge

	// reset release
	logic rst_meta_n, rst_sync_n;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// register state
	logic [1:0] run_mode, next_run_mode;
	logic overflow_flag, next_overflow_flag;
	logic ovf_recent, next_ovf_recent;
	logic cap_first_mode, next_cap_first_mode;
	logic cap_second_mode, next_cap_second_mode;
	logic [1:0] clk_sel, next_clk_sel;
	logic [1:0] edge_first, next_edge_first;
	logic [1:0] edge_second, next_edge_second;
	logic out_en, next_out_en;
	logic oneshot_en, next_oneshot_en;
	logic [15:0] count_register16, next_count;
	logic [15:0] capcmp_reg_first, next_capcmp_first;
	logic [15:0] capcmp_reg_second, next_capcmp_second;
	// count clock and event state
	logic [PRESC_W-1:0] presc, next_presc;
	logic cclk_prev, ext_fall_d;
	logic pend_first, next_pend_first;
	logic pend_second, next_pend_second;
	logic due_first, next_due_first;
	logic due_second, next_due_second;
	tmc_os_t os_state, next_os_state;
	logic os_end_first, next_os_end_first;
	logic next_out_pin, next_irq_first, next_irq_second;
	// bus state
	logic aw_got, next_aw_got;
	logic [31:0] aw_addr, next_aw_addr;
	logic w_got, next_w_got;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;

	logic running, ext_clk, int_lvl, int_rise, int_fall, cnt_tick, cnt_fall;
	logic filt_sample, edge_a, edge_b;
	logic [31:0] reg_view [REG_NONE:REG_MODE];

	assign running = (run_mode != RUN_STOP);
	assign ext_clk = (clk_sel == CLK_EXT);

	// prescaler runs free, so a start lands anywhere within a count clock period
	always_comb
	begin
		case (clk_sel)
			CLK_DIV8: int_lvl = presc[TAP_DIV8];
			CLK_DIV32: int_lvl = presc[TAP_DIV32];
			default: int_lvl = presc[TAP_DIV2];
		endcase
	end
	assign int_rise = int_lvl & ~cclk_prev;
	assign int_fall = ~int_lvl & cclk_prev;
	assign filt_sample = ext_clk ? 1'b1 : int_rise;
	assign cnt_tick = running & (ext_clk ? edge_a : int_rise);
	assign cnt_fall = running & (ext_clk ? ext_fall_d : int_fall);

	tmc_edge_filt u_filt_first (
		.ref_clk(ref_clk),
		.rst_n(rst_sync_n),
		.pin(trigger_input_first),
		.sample_en(filt_sample),
		.run(running),
		.edge_sel(edge_first),
		.edge_pulse(edge_a)
	);

	tmc_edge_filt u_filt_second (
		.ref_clk(ref_clk),
		.rst_n(rst_sync_n),
		.pin(capture_input_second),
		.sample_en(filt_sample),
		.run(running),
		.edge_sel(edge_second),
		.edge_pulse(edge_b)
	);

	// register words as software sees them
	always_comb
	begin
		for (int i = 0; i <= REG_NONE; i++)
			reg_view[i] = WORD_ZERO;
		reg_view[REG_MODE][MODE_OVF_BIT] = overflow_flag;
		reg_view[REG_MODE][MODE_RUN_HI:MODE_RUN_LO] = run_mode;
		reg_view[REG_CCR][CCR_FIRST_CAP] = cap_first_mode;
		reg_view[REG_CCR][CCR_SECOND_CAP] = cap_second_mode;
		reg_view[REG_PRM][PRM_CLK_HI:PRM_CLK_LO] = clk_sel;
		reg_view[REG_PRM][PRM_EDGE1_HI:PRM_EDGE1_LO] = edge_first;
		reg_view[REG_PRM][PRM_EDGE2_HI:PRM_EDGE2_LO] = edge_second;
		reg_view[REG_OUT][OUT_EN_BIT] = out_en;
		reg_view[REG_OUT][OUT_OS_BIT] = oneshot_en;
		reg_view[REG_CNT][CNT_W-1:0] = count_register16;
		reg_view[REG_FIRST][CNT_W-1:0] = capcmp_reg_first;
		reg_view[REG_SECOND][CNT_W-1:0] = capcmp_reg_second;
	end

	always_comb
	begin
		tmc_reg_t wr_idx, rd_idx;
		logic wr_fire, soft_wr, ovf_clr, ext_trig, os_trig, clr_start, ovf_set, os_busy;
		logic [31:0] wv;
		wr_idx = reg_decode(aw_addr);
		rd_idx = reg_decode(axi_req.araddr);
		wv = strb_merge(reg_view[wr_idx], w_data, w_strb);
		wr_fire = aw_got & w_got & ~bvalid;
		soft_wr = 1'b0;
		ovf_clr = 1'b0;
		os_busy = (os_state != OS_IDLE);
		ext_trig = edge_a & ~os_busy;
		os_trig = 1'b0;
		clr_start = 1'b0;
		ovf_set = 1'b0;
		next_aw_got = aw_got;
		next_aw_addr = aw_addr;
		next_w_got = w_got;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_run_mode = run_mode;
		next_cap_first_mode = cap_first_mode;
		next_cap_second_mode = cap_second_mode;
		next_clk_sel = clk_sel;
		next_edge_first = edge_first;
		next_edge_second = edge_second;
		next_out_en = out_en;
		next_oneshot_en = oneshot_en;
		next_capcmp_first = capcmp_reg_first;
		next_capcmp_second = capcmp_reg_second;
		// bus: address and data taken in either order, response after both
		if (axi_req.awvalid && !aw_got && !bvalid)
		begin
			next_aw_got = 1'b1;
			next_aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !w_got && !bvalid)
		begin
			next_w_got = 1'b1;
			next_w_data = axi_req.wdata;
			next_w_strb = axi_req.wstrb;
		end
		if (bvalid && axi_req.bready)
			next_bvalid = 1'b0;
		if (wr_fire)
		begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			case (wr_idx)
				REG_MODE:
				begin
					next_run_mode = wv[MODE_RUN_HI:MODE_RUN_LO];
					ovf_clr = ~wv[MODE_OVF_BIT];
				end
				REG_CCR:
				begin
					next_cap_first_mode = wv[CCR_FIRST_CAP];
					next_cap_second_mode = wv[CCR_SECOND_CAP];
				end
				REG_PRM:
				begin
					next_clk_sel = wv[PRM_CLK_HI:PRM_CLK_LO];
					next_edge_first = wv[PRM_EDGE1_HI:PRM_EDGE1_LO];
					next_edge_second = wv[PRM_EDGE2_HI:PRM_EDGE2_LO];
				end
				REG_OUT:
				begin
					next_out_en = wv[OUT_EN_BIT];
					next_oneshot_en = wv[OUT_OS_BIT];
					soft_wr = wv[OUT_SOFT_BIT];
				end
				REG_FIRST: next_capcmp_first = wv[CNT_W-1:0];
				REG_SECOND: next_capcmp_second = wv[CNT_W-1:0];
				default: ;
			endcase
		end
		if (rvalid && axi_req.rready)
			next_rvalid = 1'b0;
		if (axi_req.arvalid && !rvalid)
		begin
			// a counter read is a plain read, nothing is captured by it
			next_rvalid = 1'b1;
			next_rdata = reg_view[rd_idx];
			next_rresp = (rd_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end

		// one-shot launch: soft bit or external edge, the edge only while no one-shot is waiting or active
		os_trig = running & oneshot_en & (soft_wr | ext_trig);
		clr_start = os_trig | ((run_mode == RUN_EDGE_CLR) & edge_a);
		ovf_set = cnt_tick & (count_register16 == CNT_MAX) & ~clr_start;

		// counter
		next_count = count_register16;
		next_ovf_recent = ovf_recent;
		if (!running)
		begin
			next_count = CNT_ZERO;
			next_ovf_recent = 1'b0;
		end
		else if (clr_start)
		begin
			next_count = CNT_ZERO;
			next_ovf_recent = 1'b0;
		end
		else if (cnt_tick)
		begin
			if ((run_mode == RUN_MATCH_CLR) && !cap_first_mode && (count_register16 == capcmp_reg_first))
				next_count = CNT_ZERO;
			else
				next_count = count_register16 + CNT_ONE;
			next_ovf_recent = ovf_set;
		end
		// a clear before the counter leaves zero is overridden
		next_overflow_flag = ovf_set | ovf_recent | (overflow_flag & ~ovf_clr);

		// one-shot output state
		next_os_state = os_state;
		next_os_end_first = os_end_first;
		if (!running)
			next_os_state = OS_IDLE;
		else if (os_trig)
			next_os_state = OS_WAIT;
		else if (cnt_tick)
		begin
			case (os_state)
				OS_WAIT:
				begin
					if (count_register16 == capcmp_reg_second)
					begin
						next_os_state = OS_ACTIVE;
						next_os_end_first = 1'b1;
					end
					else if (count_register16 == capcmp_reg_first)
					begin
						next_os_state = OS_ACTIVE;
						next_os_end_first = 1'b0;
					end
				end
				OS_ACTIVE:
				begin
					if (count_register16 == (os_end_first ? capcmp_reg_first : capcmp_reg_second))
						next_os_state = OS_IDLE;
				end
				default: next_os_state = OS_IDLE;
			endcase
		end
		next_out_pin = out_en & (next_os_state == OS_ACTIVE);

		// capture: edge arms, count clock fall latches, next rise interrupts
		next_pend_first = running & ((edge_b & cap_first_mode) | (pend_first & ~cnt_fall));
		next_pend_second = running & ((edge_a & ~ext_clk & cap_second_mode)
			| (pend_second & ~cnt_fall));
		next_due_first = running & (due_first & ~cnt_tick);
		next_due_second = running & (due_second & ~cnt_tick);
		if (pend_first && cnt_fall)
		begin
			next_capcmp_first = count_register16;
			next_due_first = 1'b1;
		end
		if (pend_second && cnt_fall)
		begin
			next_capcmp_second = count_register16;
			next_due_second = 1'b1;
		end
		next_irq_first = cnt_tick & ((due_first) | (~cap_first_mode & (count_register16 == capcmp_reg_first)));
		next_irq_second = cnt_tick & ((due_second)
			| (~cap_second_mode & (count_register16 == capcmp_reg_second)));
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			aw_got <= 1'b0;
			aw_addr <= WORD_ZERO;
			w_got <= 1'b0;
			w_data <= WORD_ZERO;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= WORD_ZERO;
			rresp <= RESP_OKAY;
			run_mode <= RUN_STOP;
			overflow_flag <= 1'b0;
			ovf_recent <= 1'b0;
			cap_first_mode <= 1'b0;
			cap_second_mode <= 1'b0;
			clk_sel <= CLK_DIV2;
			edge_first <= EDGE_FALL;
			edge_second <= EDGE_FALL;
			out_en <= 1'b0;
			oneshot_en <= 1'b0;
			count_register16 <= CNT_ZERO;
			capcmp_reg_first <= CNT_ZERO;
			capcmp_reg_second <= CNT_ZERO;
			presc <= '0;
			cclk_prev <= 1'b0;
			ext_fall_d <= 1'b0;
			pend_first <= 1'b0;
			pend_second <= 1'b0;
			due_first <= 1'b0;
			due_second <= 1'b0;
			os_state <= OS_IDLE;
			os_end_first <= 1'b0;
			timer_output_pin <= 1'b0;
			match_irq_first <= 1'b0;
			match_irq_second <= 1'b0;
		end
		else
		begin
			aw_got <= next_aw_got;
			aw_addr <= next_aw_addr;
			w_got <= next_w_got;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			run_mode <= next_run_mode;
			overflow_flag <= next_overflow_flag;
			ovf_recent <= next_ovf_recent;
			cap_first_mode <= next_cap_first_mode;
			cap_second_mode <= next_cap_second_mode;
			clk_sel <= next_clk_sel;
			edge_first <= next_edge_first;
			edge_second <= next_edge_second;
			out_en <= next_out_en;
			oneshot_en <= next_oneshot_en;
			count_register16 <= next_count;
			capcmp_reg_first <= next_capcmp_first;
			capcmp_reg_second <= next_capcmp_second;
			presc <= next_presc;
			cclk_prev <= int_lvl;
			ext_fall_d <= running & ext_clk & edge_a;
			pend_first <= next_pend_first;
			pend_second <= next_pend_second;
			due_first <= next_due_first;
			due_second <= next_due_second;
			os_state <= next_os_state;
			os_end_first <= next_os_end_first;
			timer_output_pin <= next_out_pin;
			match_irq_first <= next_irq_first;
			match_irq_second <= next_irq_second;
		end
	end

	assign next_presc = presc + PRESC_W'(1);

	// bus handshakes
	assign axi_rsp.awready = ~aw_got & ~bvalid;
	assign axi_rsp.wready = ~w_got & ~bvalid;
	assign axi_rsp.bvalid = bvalid;
	assign axi_rsp.bresp = bresp;
	assign axi_rsp.arready = ~rvalid;
	assign axi_rsp.rvalid = rvalid;
	assign axi_rsp.rdata = rdata;
	assign axi_rsp.rresp = rresp;
endmodule : tmc_timer16
`default_nettype wire

/* File: src/tmc_pkg.sv */
// package: register map, field positions, codes and bus carriers for the 16-bit timer
package tmc_pkg;
	// register byte offsets
	localparam logic [31:0] OFS_MODE = 32'h0000_0000;
	localparam logic [31:0] OFS_CCR = 32'h0000_0004;
	localparam logic [31:0] OFS_PRM = 32'h0000_0008;
	localparam logic [31:0] OFS_OUT = 32'h0000_000C;
	localparam logic [31:0] OFS_CNT = 32'h0000_0010;
	localparam logic [31:0] OFS_FIRST = 32'h0000_0014;
	localparam logic [31:0] OFS_SECOND = 32'h0000_0018;
	// field positions
	localparam int MODE_OVF_BIT = 0;
	localparam int MODE_RUN_LO = 2;
	localparam int MODE_RUN_HI = 3;
	localparam int CCR_FIRST_CAP = 0;
	localparam int CCR_SECOND_CAP = 1;
	localparam int PRM_CLK_LO = 0;
	localparam int PRM_CLK_HI = 1;
	localparam int PRM_EDGE1_LO = 4;
	localparam int PRM_EDGE1_HI = 5;
	localparam int PRM_EDGE2_LO = 6;
	localparam int PRM_EDGE2_HI = 7;
	localparam int OUT_EN_BIT = 0;
	localparam int OUT_OS_BIT = 1;
	localparam int OUT_SOFT_BIT = 6;
	localparam int CNT_W = 16;
	localparam int PRESC_W = 5;
	// run modes
	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_FREE = 2'h1;
	localparam logic [1:0] RUN_EDGE_CLR = 2'h2;
	localparam logic [1:0] RUN_MATCH_CLR = 2'h3;
	// count clock selection and prescaler tap for each divided clock
	localparam logic [1:0] CLK_DIV2 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV32 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam int TAP_DIV2 = 0;
	localparam int TAP_DIV8 = 2;
	localparam int TAP_DIV32 = 4;
	// valid edge codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_NONE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef enum logic [2:0] {
		REG_MODE, REG_CCR, REG_PRM, REG_OUT, REG_CNT, REG_FIRST, REG_SECOND, REG_NONE
	} tmc_reg_t;
	typedef enum logic [1:0] {
		OS_IDLE = 2'h0,
		OS_WAIT = 2'h1,
		OS_ACTIVE = 2'h3
	} tmc_os_t;
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} tmc_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} tmc_axi_rsp_t;
endpackage : tmc_pkg

/* File: src/tmc_edge_filt.sv */
// trigger pin synchroniser, two-sample noise filter and valid edge detector
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_filt
	import tmc_pkg::*;
(
	// clock and synchronised reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pin and control
	input wire logic pin,
	input wire logic sample_en,
	input wire logic run,
	input wire logic [1:0] edge_sel,
	// detected valid edge
	output logic edge_pulse
);
	logic s1, s2, s3;
	logic samp, next_samp;
	logic level, next_level;
	logic armed, next_armed;
	logic next_edge;

	always_comb
	begin
		next_samp = samp;
		next_level = level;
		// level stays low until the first enable, so a pin already high then reads as a rise
		next_armed = armed | run;
		next_edge = 1'b0;
		if (sample_en && (s2 == s3))
		begin
			next_samp = s3;
			if ((s3 == samp) && (s3 != level) && next_armed)
			begin
				next_level = s3;
				if (run)
					next_edge = s3 ? (edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH)
						: (edge_sel == EDGE_FALL || edge_sel == EDGE_BOTH);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			samp <= 1'b0;
			level <= 1'b0;
			armed <= 1'b0;
			edge_pulse <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			samp <= next_samp;
			level <= next_level;
			armed <= next_armed;
			edge_pulse <= next_edge;
		end
	end
endmodule : tmc_edge_filt
`default_nettype wire

/* File: test/tmc_props.sv */
// checker: bus handshakes, irq pulses, one-shot edges and quiet stop of the timer
`timescale 1ns/1ps
`default_nettype none
module tmc_props
	import tmc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus
	input wire tmc_axi_req_t axi_req,
	input wire tmc_axi_rsp_t axi_rsp,
	// pins
	input wire logic trigger_input_first,
	input wire logic capture_input_second,
	input wire logic timer_output_pin,
	input wire logic match_irq_first,
	input wire logic match_irq_second
);
	logic [1:0] run;
	logic [31:0] rd_addr;
	logic [3:0] idle;
	logic aw_go;
	logic ar_go;
	assign aw_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	assign ar_go = axi_req.arvalid && axi_rsp.arready;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// run mode as software last wrote it; assumes full-word writes
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run <= RUN_STOP;
			rd_addr <= WORD_ZERO;
			idle <= 4'h0;
		end
		else
		begin
			if (aw_go && axi_req.awaddr == OFS_MODE)
				run <= axi_req.wdata[MODE_RUN_HI:MODE_RUN_LO];
			if (ar_go)
				rd_addr <= axi_req.araddr;
			if (run != RUN_STOP)
				idle <= 4'h0;
			else if (idle != 4'hF)
				idle <= idle + 4'h1;
		end
	end
	sequence s_second_near;
		##[0:2] match_irq_second;
	endsequence
	sequence s_first_near;
		##[0:2] match_irq_first;
	endsequence
	property p_bhold;
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	property p_rhold;
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
	endproperty
	property p_wresp;
		aw_go |-> ##[1:2] axi_rsp.bvalid;
	endproperty
	property p_rresp;
		ar_go |=> axi_rsp.rvalid;
	endproperty
	property p_refuse;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	property p_slverr;
		axi_rsp.rvalid && rd_addr > OFS_SECOND |-> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == WORD_ZERO;
	endproperty
	property p_irq1;
		match_irq_first |=> !match_irq_first;
	endproperty
	property p_irq2;
		match_irq_second |=> !match_irq_second;
	endproperty
	property p_quiet;
		idle == 4'hF |-> !timer_output_pin && !match_irq_first && !match_irq_second;
	endproperty
	property p_rise;
		$rose(timer_output_pin) |-> s_second_near;
	endproperty
	property p_fall;
		$fell(timer_output_pin) && run != RUN_STOP |-> s_first_near;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	a_rhold: assert property (p_rhold) else $error("read response dropped early");
	a_wresp: assert property (p_wresp) else $error("write response late");
	a_rresp: assert property (p_rresp) else $error("read response late");
	a_refuse: assert property (p_refuse) else $error("write taken during response");
	a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
	a_irq1: assert property (p_irq1) else $error("first irq longer than a cycle");
	a_irq2: assert property (p_irq2) else $error("second irq longer than a cycle");
	a_quiet: assert property (p_quiet) else $error("activity while stopped");
	a_rise: assert property (p_rise) else $error("output rose without second match");
	a_fall: assert property (p_fall) else $error("output fell without first match");
endmodule : tmc_props
bind tmc_timer16 tmc_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.trigger_input_first(trigger_input_first), .capture_input_second(capture_input_second),
	.timer_output_pin(timer_output_pin), .match_irq_first(match_irq_first), .match_irq_second(match_irq_second));
`default_nettype wire

/* File: test/tmc_pin_model.sv */
// pin model: trigger and capture sources that hold each level a minimum time
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model #(
	parameter int HOLD = 10
)
(
	// clock and requested levels
	input wire logic ref_clk,
	input wire logic want_trig,
	input wire logic want_cap,
	// pins
	output logic trigger_input_first,
	output logic capture_input_second
);
	int age_t = 0;
	int age_c = 0;
	initial trigger_input_first = 1'b0;
	initial capture_input_second = 1'b0;
	// a level change waits until the old level is old enough to be sampled twice
	always @(posedge ref_clk)
	begin
		age_t <= age_t + 1;
		age_c <= age_c + 1;
		if (want_trig !== trigger_input_first && age_t >= HOLD)
		begin
			trigger_input_first <= want_trig;
			age_t <= 0;
		end
		if (want_cap !== capture_input_second && age_c >= HOLD)
		begin
			capture_input_second <= want_cap;
			age_c <= 0;
		end
	end
endmodule : tmc_pin_model
`default_nettype wire

/* File: test/testbench.sv */
// testbench: register bus, one-shot pulses, external triggers and capture
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tmc_pkg::*;
;
	logic ref_clk;
	logic rst_n;
	tmc_axi_req_t req;
	tmc_axi_rsp_t rsp;
	logic trig, cap, pin, irq1, irq2, want_trig, want_cap;
	int errors, compares, irq1_cnt, n, m, w, c0;
	logic [31:0] v, c, a;
	logic [1:0] edges [3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
	tmc_timer16 uut (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
		.trigger_input_first(trig), .capture_input_second(cap), .timer_output_pin(pin),
		.match_irq_first(irq1), .match_irq_second(irq2));
	tmc_pin_model u_pins (.ref_clk(ref_clk), .want_trig(want_trig), .want_cap(want_cap),
		.trigger_input_first(trig), .capture_input_second(cap));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk)
		if (irq1 === 1'b1)
			irq1_cnt++;
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic sig(input int s);
		case (s)
			0: return rsp.awready & rsp.wready;
			1: return rsp.bvalid;
			2: return rsp.arready;
			3: return rsp.rvalid;
			4: return pin;
			5: return ~pin;
			default: return irq1;
		endcase
	endfunction : sig
	// ready levels seen at the falling edge still hold at the next rising edge
	task automatic await(input int s, input int lim, output int k);
		k = 0;
		do
		begin
			@(negedge ref_clk);
			k++;
		end
		while (sig(s) !== 1'b1 && k < lim);
		if (sig(s) !== 1'b1)
		begin
			errors++;
			$display("[FAIL] wait %0d expected 1 seen 0", s);
			final_report();
		end
	endtask : await
	task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] er);
		int k;
		req.awaddr <= ad;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		await(0, 100, k);
		@(posedge ref_clk);
		req.awvalid <= 1'b0;
		req.wvalid <= 1'b0;
		await(1, 100, k);
		check("bresp", {30'h0, rsp.bresp}, {30'h0, er});
		@(posedge ref_clk);
		req.bready <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [31:0] ad, output logic [31:0] d, input logic [1:0] er);
		int k;
		req.araddr <= ad;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		await(2, 100, k);
		@(posedge ref_clk);
		req.arvalid <= 1'b0;
		await(3, 100, k);
		d = rsp.rdata;
		check("rresp", {30'h0, rsp.rresp}, {30'h0, er});
		@(posedge ref_clk);
		req.rready <= 1'b0;
		@(posedge ref_clk);
	endtask : rd
	function automatic int width_of(input int on_at, input int off_at);
		return (off_at - on_at) * 2;
	endfunction : width_of
	// optionally toggles the trigger pin twice while the pulse is high
	task automatic pulse(input bit re, output int wid);
		int k;
		await(4, 600, k);
		fork
			await(5, 300, wid);
			if (re)
			begin
				@(negedge ref_clk);
				want_trig <= ~want_trig;
				repeat (12) @(negedge ref_clk);
				want_trig <= ~want_trig;
			end
		join
		@(posedge ref_clk);
	endtask : pulse
	initial
	begin
		rst_n = 1'b0;
		req = '0;
		want_trig = 1'b0;
		want_cap = 1'b0;
		errors = 0;
		compares = 0;
		irq1_cnt = 0;
		void'($urandom(70744));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(OFS_CNT, v, RESP_OKAY);
		check("count reset", v, WORD_ZERO);
		a = 32'h0000_001C + 32'($urandom_range(8)) * 32'h0000_0004;
		wr(a, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(a, v, RESP_SLVERR);
		check("unmapped data", v, WORD_ZERO);
		rd(OFS_MODE, v, RESP_OKAY);
		check("mode reset", v, WORD_ZERO);
		$display("test map done");
		n = 4 + $urandom_range(7);
		m = n + 14 + $urandom_range(7);
		wr(OFS_SECOND, 32'(n), RESP_OKAY);
		wr(OFS_FIRST, 32'(m), RESP_OKAY);
		wr(OFS_OUT, 32'h0000_0003, RESP_OKAY);
		wr(OFS_MODE, 32'h0000_0004, RESP_OKAY);
		rd(OFS_CNT, v, RESP_OKAY);
		check("counting", 32'(v != WORD_ZERO && v < 32'h0000_0010), 32'h0000_0001);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_OUT, 32'h0000_0043, RESP_OKAY);
			pulse(1'b0, w);
			check("soft width", 32'(w), 32'(width_of(n, m)));
		end
		$display("test soft one-shot done");
		for (int k = 0; k < 3; k++)
		begin
			wr(OFS_MODE, WORD_ZERO, RESP_OKAY);
			wr(OFS_PRM, {24'h0, edges[k], 4'h0}, RESP_OKAY);
			wr(OFS_MODE, 32'h0000_0004, RESP_OKAY);
			want_trig <= ~want_trig;
			pulse(1'b1, w);
			check("trigger width", 32'(w), 32'(width_of(n, m)));
		end
		$display("test external trigger done");
		wr(OFS_MODE, WORD_ZERO, RESP_OKAY);
		wr(OFS_SECOND, 32'h0000_1234, RESP_OKAY);
		wr(OFS_FIRST, 32'h0000_ABCD, RESP_OKAY);
		wr(OFS_CCR, 32'h0000_0003, RESP_OKAY);
		wr(OFS_PRM, 32'h0000_00D0, RESP_OKAY);
		c0 = irq1_cnt;
		want_cap <= 1'b1;
		repeat (30) @(posedge ref_clk);
		want_cap <= 1'b0;
		repeat (30) @(posedge ref_clk);
		check("irq while stopped", 32'(irq1_cnt - c0), WORD_ZERO);
		wr(OFS_MODE, 32'h0000_0004, RESP_OKAY);
		rd(OFS_CNT, v, RESP_OKAY);
		rd(OFS_SECOND, v, RESP_OKAY);
		check("second after count read", v, 32'h0000_1234);
		want_cap <= 1'b1;
		await(6, 100, w);
		@(posedge ref_clk);
		rd(OFS_FIRST, v, RESP_OKAY);
		rd(OFS_CNT, c, RESP_OKAY);
		check("captured below count", 32'(v[15:0] < c[15:0]), 32'h0000_0001);
		wr(OFS_MODE, WORD_ZERO, RESP_OKAY);
		repeat (20) @(posedge ref_clk);
		$display("test capture done");
		wr(OFS_FIRST, 32'(m), RESP_OKAY);
		wr(OFS_CCR, WORD_ZERO, RESP_OKAY);
		wr(OFS_PRM, 32'(CLK_DIV8), RESP_OKAY);
		wr(OFS_MODE, 32'h0000_000C, RESP_OKAY);
		await(6, 600, w);
		await(6, 600, w);
		check("match period", 32'(w), 32'((m + 1) << (TAP_DIV8 + 1)));
		$display("test match clear done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
